/* core/pmcc_map.vh */
// Register offsets, field positions, reset values and timing counts of the channel configuration block
`ifndef PMCC_MAP_VH
`define PMCC_MAP_VH

// ------------------------------------------------------------------
// Command codes (register offsets)
// ------------------------------------------------------------------
`define PMCC_OFS_CUR_SCALE   8'h38
`define PMCC_OFS_VCH_CFG     8'hD5
`define PMCC_OFS_TRACK_CFG   8'hD7
`define PMCC_OFS_EXC_CFG     8'hE2

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define PMCC_SCALE_MSB       14
`define PMCC_AUX_BUS_VOLTAGE_AVG_MSB    13
`define PMCC_AUX_BUS_VOLTAGE_AVG_LSB    10
`define PMCC_AUX_BUS_VOLTAGE_CT_MSB     9
`define PMCC_AUX_BUS_VOLTAGE_CT_LSB     7
`define PMCC_VBUS_AVG_MSB    6
`define PMCC_VBUS_AVG_LSB    3
`define PMCC_VBUS_CT_MSB     2
`define PMCC_VBUS_CT_LSB     0
`define PMCC_VCH_CFG_MSB     13
`define PMCC_TRACK_EN_BIT    0
`define PMCC_EXC_EN_BIT      0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PMCC_RST_CUR_SCALE   15'h0000
`define PMCC_RST_VCH_CFG     14'h0387
`define PMCC_RST_TRACK_EN    1'b0
`define PMCC_RST_EXC_EN      1'b0

// ------------------------------------------------------------------
// Arithmetic and timing
// ------------------------------------------------------------------
`define PMCC_MATH_SHIFT      11
`define PMCC_AVG_MAX_LOG2    12
`define PMCC_CLK_MHZ         100
`define PMCC_CONV_BASE_US    64
`define PMCC_EXC_TIME_NS     1000
`define PMCC_CLK_PERIOD_NS   10

`endif

/* core/pmcc_channel_config.v */
// Channel configuration, current and power math, min/max tracking and diode temperature sequencing
`timescale 1ns/10ps
`include "pmcc_map.vh"

module pmcc_channel_config #(
  parameter CONV_BASE_CYC = `PMCC_CONV_BASE_US * `PMCC_CLK_MHZ  // Cycles of the 64us step
) (
  input  wire        CORE_CLK_I,       // Core clock, 100 MHz
  input  wire        RESETN_I,         // Async reset, active low
  input  wire        REG_WR_I,         // Register write strobe
  input  wire        REG_RD_I,         // Register read strobe
  input  wire [7:0]  REG_CMD_I,        // Command code
  input  wire [15:0] REG_WDATA_I,      // Write data
  output reg  [15:0] REG_RDATA_O,      // Read data
  output reg         REG_ACK_O,        // Access hit a mapped code
  input  wire        PRIM_VALID_I,     // New primary shunt/bus sample
  input  wire [15:0] SHUNT_DATA_I,     // Signed shunt sample
  input  wire [15:0] VBUS_DATA_I,      // Unsigned bus sample
  output reg  [15:0] CURRENT_RESULT_O, // Current result
  output reg  [15:0] POWER_RESULT_O,   // Power result
  output reg  [15:0] PEAK_MIN_O,       // Minimum tracked current
  output reg  [15:0] PEAK_MAX_O,       // Maximum tracked current
  output wire [3:0]  VBUS_AVG_O,       // Bus averaging code
  output wire [2:0]  VBUS_CT_O,        // Bus conversion-time code
  output wire [3:0]  AUX_BUS_VOLTAGE_AVG_O,       // Aux bus averaging code
  output wire [2:0]  AUX_BUS_VOLTAGE_CT_O,        // Aux bus conversion-time code
  output wire [19:0] VBUS_CONV_CYC_O,  // Bus conversion length in cycles
  output wire [19:0] AUX_BUS_VOLTAGE_CONV_CYC_O,  // Aux bus conversion length in cycles
  input  wire        TEMP_MODE_I,      // Mode logic selects temperature
  input  wire [3:0]  AUX_SHUNT_AVG_I,  // Aux shunt averaging code
  input  wire [2:0]  AUX_SHUNT_CT_I,   // Aux shunt conversion-time code
  input  wire [15:0] AUX_DIFF_I,       // Signed difference of held samples
  output reg         EXCITE_EN_O,      // Current source on
  output reg         EXCITE_HI_O,      // High current selected
  output reg         HOLD_LO_O,        // Hold sample at low current
  output reg         HOLD_HI_O,        // Hold sample at high current
  output reg  [15:0] TEMP_RESULT_O,    // Temperature result
  output reg         TEMP_VALID_O      // Result update pulse
);

  // ------------------------------------------------------------------
  // Local constants
  // ------------------------------------------------------------------
  // Worked out as integers, then cut to the counter widths on purpose
  localparam integer EXC_CYC_INT   = `PMCC_EXC_TIME_NS / `PMCC_CLK_PERIOD_NS;
  localparam [7:0]   EXC_CYC       = EXC_CYC_INT[7:0];
  localparam [7:0]   EXC_HALF      = EXC_CYC / 8'd2;
  localparam integer CONV_BASE_INT = CONV_BASE_CYC;
  localparam [19:0]  CONV_BASE     = CONV_BASE_INT[19:0];
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOW  = 5'h02;
  localparam [4:0] ST_HIGH = 5'h04;
  localparam [4:0] ST_CONV = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  // Conversion length: codes 0..3 give 1x, 2x, 4x and 8x the base, 10x gives 16x and 11x gives 32x the base
  function [19:0] conv_cycles;
    input [2:0] code;
    begin
      if (code[2]) begin
        conv_cycles = code[1] ? (CONV_BASE << 5) : (CONV_BASE << 4);
      end else begin
        conv_cycles = CONV_BASE << code[1:0];
      end
    end
  endfunction

  // Averaging exponent: 11xx means 4096 samples
  function [3:0] avg_log2;
    input [3:0] code;
    begin
      avg_log2 = (code[3:2] == 2'b11) ? 4'd12 : code;
    end
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg [14:0] cur_scale;
  reg [13:0] vch_cfg;
  reg        track_en;
  reg        exc_en;

  // Writes keep only implemented bits, so upper bits stay zero
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cur_scale <= `PMCC_RST_CUR_SCALE;
      vch_cfg   <= `PMCC_RST_VCH_CFG;
      track_en  <= `PMCC_RST_TRACK_EN;
      exc_en    <= `PMCC_RST_EXC_EN;
    end else if (REG_WR_I) begin
      case (REG_CMD_I)
        `PMCC_OFS_CUR_SCALE: cur_scale <= REG_WDATA_I[`PMCC_SCALE_MSB:0];
        `PMCC_OFS_VCH_CFG:   vch_cfg   <= REG_WDATA_I[`PMCC_VCH_CFG_MSB:0];
        `PMCC_OFS_TRACK_CFG: track_en  <= REG_WDATA_I[`PMCC_TRACK_EN_BIT];
        `PMCC_OFS_EXC_CFG:   exc_en    <= REG_WDATA_I[`PMCC_EXC_EN_BIT];
        default:             cur_scale <= cur_scale;
      endcase
    end
  end

  // Read mux, registered; unmapped codes answer zero with no ack
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 16'h0000;
      REG_ACK_O   <= 1'b0;
    end else begin
      REG_ACK_O <= 1'b0;
      if (REG_WR_I || REG_RD_I) begin
        case (REG_CMD_I)
          `PMCC_OFS_CUR_SCALE: REG_ACK_O <= 1'b1;
          `PMCC_OFS_VCH_CFG:   REG_ACK_O <= 1'b1;
          `PMCC_OFS_TRACK_CFG: REG_ACK_O <= 1'b1;
          `PMCC_OFS_EXC_CFG:   REG_ACK_O <= 1'b1;
          default:             REG_ACK_O <= 1'b0;
        endcase
      end
      if (REG_RD_I) begin
        case (REG_CMD_I)
          `PMCC_OFS_CUR_SCALE: REG_RDATA_O <= {1'b0, cur_scale};
          `PMCC_OFS_VCH_CFG:   REG_RDATA_O <= {2'b00, vch_cfg};
          `PMCC_OFS_TRACK_CFG: REG_RDATA_O <= {15'h0000, track_en};
          `PMCC_OFS_EXC_CFG:   REG_RDATA_O <= {15'h0000, exc_en};
          default:             REG_RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Voltage channel settings out to the front end
  // ------------------------------------------------------------------
  assign VBUS_AVG_O      = vch_cfg[`PMCC_VBUS_AVG_MSB:`PMCC_VBUS_AVG_LSB];
  assign VBUS_CT_O       = vch_cfg[`PMCC_VBUS_CT_MSB:`PMCC_VBUS_CT_LSB];
  assign AUX_BUS_VOLTAGE_AVG_O      = vch_cfg[`PMCC_AUX_BUS_VOLTAGE_AVG_MSB:`PMCC_AUX_BUS_VOLTAGE_AVG_LSB];
  assign AUX_BUS_VOLTAGE_CT_O       = vch_cfg[`PMCC_AUX_BUS_VOLTAGE_CT_MSB:`PMCC_AUX_BUS_VOLTAGE_CT_LSB];
  // Same decoding as the shunt channels
  assign VBUS_CONV_CYC_O = conv_cycles(VBUS_CT_O);
  assign AUX_BUS_VOLTAGE_CONV_CYC_O = conv_cycles(AUX_BUS_VOLTAGE_CT_O);

  // ------------------------------------------------------------------
  // Current and power math
  // ------------------------------------------------------------------
  // Shunt sample is sign-extended; scale is zero-extended as positive
  // Full-scale shunt input spans the whole signed sample, so the scale sets the step
  wire signed [31:0] cur_prod = $signed(SHUNT_DATA_I) * $signed({1'b0, cur_scale});
  wire signed [15:0] cur_val  = cur_prod[`PMCC_MATH_SHIFT+15:`PMCC_MATH_SHIFT];
  // Power uses the fresh current, so both results come from one sample
  wire signed [32:0] pwr_prod = cur_val * $signed({1'b0, VBUS_DATA_I});
  wire signed [15:0] pwr_val  = pwr_prod[`PMCC_MATH_SHIFT+15:`PMCC_MATH_SHIFT];

  // Results update on every sample; a zero scale forces zero products
  // Limitation: no overflow flag here, products beyond 16 bits simply wrap
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CURRENT_RESULT_O <= 16'h0000;
      POWER_RESULT_O   <= 16'h0000;
    end else if (PRIM_VALID_I) begin
      CURRENT_RESULT_O <= (cur_scale == 15'h0000) ? 16'h0000 : cur_val;
      POWER_RESULT_O   <= (cur_scale == 15'h0000) ? 16'h0000 : pwr_val;
    end
  end

  // ------------------------------------------------------------------
  // Min/max current tracking
  // ------------------------------------------------------------------
  reg track_first;

  // Disable clears both and rearms so the next result seeds them
  // Comparing the registered result lags one sample but keeps the multiplier off this path
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PEAK_MIN_O  <= 16'h0000;
      PEAK_MAX_O  <= 16'h0000;
      track_first <= 1'b1;
    end else if (!track_en) begin
      PEAK_MIN_O  <= 16'h0000;
      PEAK_MAX_O  <= 16'h0000;
      track_first <= 1'b1;
    end else if (PRIM_VALID_I) begin
      track_first <= 1'b0;
      if (track_first || ($signed(CURRENT_RESULT_O) < $signed(PEAK_MIN_O))) begin
        PEAK_MIN_O <= CURRENT_RESULT_O;
      end
      if (track_first || ($signed(CURRENT_RESULT_O) > $signed(PEAK_MAX_O))) begin
        PEAK_MAX_O <= CURRENT_RESULT_O;
      end
    end
  end

  // ------------------------------------------------------------------
  // Diode temperature sequencer
  // ------------------------------------------------------------------
  reg [4:0]         state;
  reg [19:0]        timer;
  reg [12:0]        samp_cnt;
  reg signed [27:0] acc;
  wire [3:0]        temp_log2 = avg_log2(AUX_SHUNT_AVG_I);
  wire [12:0]       samp_goal = 13'h0001 << temp_log2;
  wire signed [27:0] acc_next = acc + {{12{AUX_DIFF_I[15]}}, AUX_DIFF_I};
  wire signed [27:0] avg_val  = acc_next >>> temp_log2;
  // Aux settings are read live: change them only while the mode is off
  wire              temp_run = exc_en && TEMP_MODE_I;

  // Excitation alone only powers the source; the cycle needs mode 6 too
  // Dropping either condition aborts and clears the running average
  always @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state         <= ST_IDLE;
      timer         <= 20'h00000;
      samp_cnt      <= 13'h0000;
      acc           <= 28'h0000000;
      EXCITE_EN_O   <= 1'b0;
      EXCITE_HI_O   <= 1'b0;
      HOLD_LO_O     <= 1'b0;
      HOLD_HI_O     <= 1'b0;
      TEMP_RESULT_O <= 16'h0000;
      TEMP_VALID_O  <= 1'b0;
    end else begin
      TEMP_VALID_O <= 1'b0;
      EXCITE_EN_O  <= exc_en;
      HOLD_LO_O    <= 1'b0;
      HOLD_HI_O    <= 1'b0;
      if (!temp_run) begin
        state       <= ST_IDLE;
        EXCITE_HI_O <= 1'b0;
        samp_cnt    <= 13'h0000;
        acc         <= 28'h0000000;
      end else begin
        case (state)
          ST_IDLE: begin
            state       <= ST_LOW;
            timer       <= {12'h000, EXC_HALF};
            EXCITE_HI_O <= 1'b0;
          end
          ST_LOW: begin
            if (timer == 20'h00001) begin
              HOLD_LO_O   <= 1'b1;
              EXCITE_HI_O <= 1'b1;
              timer       <= {12'h000, EXC_HALF};
              state       <= ST_HIGH;
            end else begin
              timer <= timer - 20'h00001;
            end
          end
          ST_HIGH: begin
            if (timer == 20'h00001) begin
              HOLD_HI_O   <= 1'b1;
              EXCITE_HI_O <= 1'b0;
              timer       <= conv_cycles(AUX_SHUNT_CT_I);
              state       <= ST_CONV;
            end else begin
              timer <= timer - 20'h00001;
            end
          end
          ST_CONV: begin
            if (timer == 20'h00001) begin
              state <= ST_DONE;
            end else begin
              timer <= timer - 20'h00001;
            end
          end
          ST_DONE: begin
            // Converter output is the held difference; average it
            state <= ST_IDLE;
            if (samp_cnt + 13'h0001 >= samp_goal) begin
              TEMP_RESULT_O <= avg_val[15:0];
              TEMP_VALID_O  <= 1'b1;
              samp_cnt      <= 13'h0000;
              acc           <= 28'h0000000;
            end else begin
              samp_cnt <= samp_cnt + 13'h0001;
              acc      <= acc_next;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* verification/pmcc_cfg_assertions.sv */
// Port-level assertions for the channel configuration block
`timescale 1ns/10ps
module pmcc_cfg_assertions (
  input wire        CORE_CLK_I,   // Clock
  input wire        RESETN_I,     // Reset, active low
  input wire        REG_WR_I,     // Write strobe
  input wire        REG_RD_I,     // Read strobe
  input wire [7:0]  REG_CMD_I,    // Command code
  input wire [15:0] REG_WDATA_I,  // Write data
  input wire [15:0] REG_RDATA_O,  // Read data
  input wire        REG_ACK_O,    // Access answer
  input wire [3:0]  VBUS_AVG_O,   // Bus averaging
  input wire [2:0]  VBUS_CT_O,    // Bus time
  input wire [3:0]  AUX_BUS_VOLTAGE_AVG_O,   // Aux averaging
  input wire [2:0]  AUX_BUS_VOLTAGE_CT_O,    // Aux time
  input wire        TEMP_MODE_I,  // Temperature mode
  input wire        EXCITE_EN_O,  // Source on
  input wire        EXCITE_HI_O,  // High current selected
  input wire        HOLD_LO_O,    // Low hold pulse
  input wire        HOLD_HI_O,    // High hold pulse
  input wire        TEMP_VALID_O  // Result pulse
);
  // ------------------------------------------------------------------
  // Code decode and checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire hit = REG_CMD_I == 8'h38 || REG_CMD_I == 8'hD5 || REG_CMD_I == 8'hD7 || REG_CMD_I == 8'hE2;
  wire rd_bit = REG_RD_I && (REG_CMD_I == 8'hD7 || REG_CMD_I == 8'hE2);
  chk_ack_mapped: assert property (##1 REG_ACK_O == $past((REG_WR_I || REG_RD_I) && hit))
    else $error("ack does not follow a mapped access");
  chk_scale_top: assert property (REG_RD_I && REG_CMD_I == 8'h38 |=> !REG_RDATA_O[15])
    else $error("scale top bit reads as one");
  chk_vch_top: assert property (REG_RD_I && REG_CMD_I == 8'hD5 |=> REG_RDATA_O[15:14] == 2'h0)
    else $error("voltage config upper bits not zero");
  chk_bit_regs: assert property (rd_bit |=> REG_RDATA_O[15:1] == 15'h0)
    else $error("single-bit register upper bits not zero");
  chk_unmap_zero: assert property (REG_RD_I && !hit |=> REG_RDATA_O == 16'h0)
    else $error("unmapped read not zero");
  chk_vch_fields: assert property (REG_WR_I && REG_CMD_I == 8'hD5 |=>
    {AUX_BUS_VOLTAGE_AVG_O, AUX_BUS_VOLTAGE_CT_O, VBUS_AVG_O, VBUS_CT_O} == $past(REG_WDATA_I[13:0]))
    else $error("voltage config fields misplaced");
  chk_exc_lag: assert property (REG_WR_I && REG_CMD_I == 8'hE2 |=> ##1 EXCITE_EN_O == $past(REG_WDATA_I[0], 2))
    else $error("excitation output does not follow its bit");
  chk_hold_gap: assert property (HOLD_LO_O |-> ##[45:55] (HOLD_HI_O || !TEMP_MODE_I))
    else $error("high hold not about half a microsecond after low hold");
  chk_hi_on_hold: assert property (HOLD_LO_O |-> EXCITE_HI_O)
    else $error("high current not selected at low hold");
  chk_hi_off_hold: assert property (HOLD_HI_O |-> !EXCITE_HI_O)
    else $error("high current still selected at high hold");
  chk_hi_needs_source: assert property (EXCITE_HI_O |-> EXCITE_EN_O)
    else $error("high current selected with source off");
  chk_valid_pulse: assert property (TEMP_VALID_O |=> !TEMP_VALID_O)
    else $error("result pulse longer than one cycle");
  cover property (HOLD_HI_O);
  cover property (TEMP_VALID_O);
  cover property (REG_WR_I && REG_CMD_I == 8'hE2);
endmodule
bind pmcc_channel_config pmcc_cfg_assertions u_pmcc_cfg_assertions (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_CMD_I(REG_CMD_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O),
  .VBUS_AVG_O(VBUS_AVG_O), .VBUS_CT_O(VBUS_CT_O), .AUX_BUS_VOLTAGE_AVG_O(AUX_BUS_VOLTAGE_AVG_O), .AUX_BUS_VOLTAGE_CT_O(AUX_BUS_VOLTAGE_CT_O),
  .TEMP_MODE_I(TEMP_MODE_I), .EXCITE_EN_O(EXCITE_EN_O), .EXCITE_HI_O(EXCITE_HI_O),
  .HOLD_LO_O(HOLD_LO_O), .HOLD_HI_O(HOLD_HI_O),
  .TEMP_VALID_O(TEMP_VALID_O));

/* verification/pmcc_afe_model.sv */
// Analog front end stand-in: held diode voltages and plain aux input
`timescale 1ns/10ps
module pmcc_afe_model (
  input  wire        clk_i,      // Core clock
  input  wire        excite_i,   // Current source on
  input  wire        hold_lo_i,  // Take low-current sample
  input  wire        hold_hi_i,  // Take high-current sample
  input  wire [15:0] vbe_lo_i,   // Diode voltage, low current
  input  wire [15:0] vbe_hi_i,   // Diode voltage, high current
  input  wire [15:0] plain_i,    // Plain differential input
  output wire [15:0] aux_diff_o  // Value handed to converter
);
  reg [15:0] held_lo;
  reg [15:0] held_hi;
  // ------------------------------------------------------------------
  // Sample and hold per forced current
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (hold_lo_i) held_lo <= vbe_lo_i;
    if (hold_hi_i) held_hi <= vbe_hi_i;
  end
  // Unknown until both holds taken, so a premature sample shows up
  assign aux_diff_o = excite_i ? held_hi - held_lo : plain_i;
endmodule

/* verification/pmcc_channel_config_tb.sv */
// Self-checking bench for the channel configuration block
`timescale 1ns/10ps
module pmcc_channel_config_tb;
  localparam int BASE = 4;  // Short step keeps diode runs brief
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, pv = 0, tmode = 0, trk = 0, seeded = 0;
  logic [7:0]  cmd = 0;
  logic [15:0] wd = 0, sh = 0, vb = 0, vlo = 0, vhi = 0, prv = 0, emn, emx, r;
  logic [15:0] rdat, cur, pow, pmn, pmx, tres, adif;
  logic [3:0]  vav, aav, sav = 0;
  logic [2:0]  vct, act, sct = 0;
  logic [19:0] vcy, acy;
  logic        ack, exen, hlo, hhi, tval;
  logic [14:0] k = 0;
  integer      num_errors = 0, samples_checked = 0, cyc = 0, nh = 0, i, seed = 32'h9879cd9b;
  logic [7:0]  cmds [4] = '{8'h38, 8'hD5, 8'hD7, 8'hE2};
  logic [15:0] msk [4] = '{16'h7FFF, 16'h3FFF, 16'h0001, 16'h0001};
  logic [15:0] rstv [4] = '{16'h0000, 16'h0387, 16'h0000, 16'h0000};

  pmcc_channel_config #(.CONV_BASE_CYC(BASE)) u_pmcc_channel_config (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_CMD_I(cmd),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_ACK_O(ack), .PRIM_VALID_I(pv), .SHUNT_DATA_I(sh),
    .VBUS_DATA_I(vb), .CURRENT_RESULT_O(cur), .POWER_RESULT_O(pow), .PEAK_MIN_O(pmn), .PEAK_MAX_O(pmx),
    .VBUS_AVG_O(vav), .VBUS_CT_O(vct), .AUX_BUS_VOLTAGE_AVG_O(aav), .AUX_BUS_VOLTAGE_CT_O(act), .VBUS_CONV_CYC_O(vcy),
    .AUX_BUS_VOLTAGE_CONV_CYC_O(acy), .TEMP_MODE_I(tmode), .AUX_SHUNT_AVG_I(sav), .AUX_SHUNT_CT_I(sct),
    .AUX_DIFF_I(adif), .EXCITE_EN_O(exen), .EXCITE_HI_O(), .HOLD_LO_O(hlo), .HOLD_HI_O(hhi),
    .TEMP_RESULT_O(tres), .TEMP_VALID_O(tval));
  pmcc_afe_model u_pmcc_afe_model (.clk_i(clk), .excite_i(exen), .hold_lo_i(hlo), .hold_hi_i(hhi),
    .vbe_lo_i(vlo), .vbe_hi_i(vhi), .plain_i(sh), .aux_diff_o(adif));

  // ------------------------------------------------------------------
  // Clock, hang guard, hold counter
  // ------------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (hhi === 1'b1) nh = nh + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Expectations, compare and drivers
  // ------------------------------------------------------------------
  function automatic logic [15:0] f_cur(input logic [15:0] s, input logic [14:0] g);
    logic signed [31:0] p;
    p = $signed(s) * $signed({1'b0, g});
    return p[26:11];
  endfunction
  function automatic logic [15:0] f_pow(input logic [15:0] c, input logic [15:0] v);
    logic signed [32:0] p;
    p = $signed(c) * $signed({1'b0, v});
    return p[26:11];
  endfunction
  function automatic logic [19:0] f_cyc(input logic [2:0] c);
    return c[2] ? BASE << (c[1] ? 5 : 4) : BASE << c;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access; answer sampled just after the taking edge
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    cmd <= c;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  // Peaks see the current result held before this sample lands
  task automatic samp(input logic [15:0] s, input logic [15:0] v);
    @(posedge clk);
    pv <= 1'b1;
    sh <= s;
    vb <= v;
    @(posedge clk);
    pv <= 1'b0;
    #1;
    if (trk && !seeded) begin
      emn = prv;
      emx = prv;
      seeded = 1'b1;
    end
    if (trk && $signed(prv) < $signed(emn)) emn = prv;
    if (trk && $signed(prv) > $signed(emx)) emx = prv;
    prv = f_cur(s, k);
    chk("current", cur, prv);
    chk("power", pow, f_pow(prv, v));
    chk("peak_min", pmn, trk ? emn : 16'h0);
    chk("peak_max", pmx, trk ? emx : 16'h0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      acc(1'b0, cmds[i], 16'h0);
      chk("reset_value", rdat, rstv[i]);
      chk("ack", ack, 1'b1);
      r = 16'($random(seed));
      acc(1'b1, cmds[i], r);
      acc(1'b0, cmds[i], 16'h0);
      chk("readback", rdat, r & msk[i]);
      acc(1'b1, cmds[i], rstv[i]);
    end
    acc(1'b1, 8'h39, 16'hFFFF);
    chk("unmapped_ack", ack, 1'b0);
    acc(1'b0, 8'h39, 16'h0);
    chk("unmapped_data", rdat, 16'h0);
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 8'hD5, {2'b00, 4'(i), 3'(i), 4'(15 - i), 3'(7 - i)});
      chk("fields", {aav, act, vav, vct}, {4'(i), 3'(i), 4'(15 - i), 3'(7 - i)});
      chk("bus_cycles", vcy, f_cyc(3'(7 - i)));
      chk("aux_cycles", acy, f_cyc(3'(i)));
    end
    for (i = 0; i < 12; i++) begin
      if (i == 2) k = 15'($random(seed));
      if (i == 2) acc(1'b1, 8'h38, {1'b1, k});
      if (i == 4) acc(1'b1, 8'hD7, 16'h00FF);
      trk = i >= 4 && i < 10;
      if (i == 10) acc(1'b1, 8'hD7, 16'h0);
      seeded = seeded && trk;
      samp(i == 5 ? 16'h8000 : 16'($random(seed)), 16'($random(seed)));
    end
    // Mode alone must not start diode sequencing
    @(posedge clk);
    tmode <= 1'b1;
    nh = 0;
    repeat (300) @(posedge clk);
    chk("idle_holds", nh, 0);
    acc(1'b1, 8'hE2, 16'h0001);
    @(posedge clk);
    #1;
    chk("excite_on", exen, 1'b1);
    // Settings change only with the mode off, so each run starts clean
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      tmode <= 1'b0;
      sav <= 4'(i * 2);
      sct <= 3'(i * 3);
      vlo <= 16'($random(seed));
      vhi <= 16'($random(seed));
      repeat (60) @(posedge clk);
      nh = 0;
      tmode <= 1'b1;
      // Sixteen samples at the longest step here need about 3700 cycles
      for (int n = 0; n < 5000 && tval !== 1'b1; n++) @(posedge clk) #1;
      chk("temp_result", tres, 16'(vhi - vlo));
      chk("sample_count", nh, 1 << (i * 2));
    end
    @(posedge clk);
    tmode <= 1'b0;
    acc(1'b1, 8'hE2, 16'h0);
    @(posedge clk);
    #1;
    chk("excite_off", exen, 1'b0);
    test_done();
  end
endmodule
